/* File: rtl/lsb_pkg.sv */
// Constants for the LED scan and blink timing control block
package lsb_pkg;
  // Register offsets
  localparam logic [7:0] LSB_ADDR_SCAN = 8'h0b;
  localparam logic [7:0] LSB_ADDR_FEAT = 8'h0e;
  // Reset values
  localparam logic [7:0] LSB_SCAN_RST = 8'h00;
  localparam logic [7:0] LSB_FEAT_RST = 8'h00;
  // Feature field positions
  localparam int LSB_F_EXT_CLK = 0;
  localparam int LSB_F_SOFT_RST = 1;
  localparam int LSB_F_HEX = 2;
  localparam int LSB_F_UNUSED = 3;
  localparam int LSB_F_BLINK_EN = 4;
  localparam int LSB_F_BLINK_SLOW = 5;
  localparam int LSB_F_SYNC = 6;
  localparam int LSB_F_BLINK_START = 7;
  // Scan field width and digit count
  localparam int LSB_LIMIT_W = 3;
  localparam int LSB_DIGITS = 8;
  // Refresh: ten steps per oscillator cycle, N digits plus two idle steps
  localparam int LSB_STEPS_PER_OSC = 10;
  localparam int LSB_IDLE_STEPS = 2;
  // Blink half periods in milliseconds
  localparam int LSB_BLINK_FAST_HALF_MS = 500;
  localparam int LSB_BLINK_SLOW_HALF_MS = 1000;
  // Core clock
  localparam int LSB_CLK_HZ = 10_000_000;
endpackage : lsb_pkg

/* File: rtl/lsb_scan_blink.sv */
// LED multiplex scan and blink timing control with its two registers
`timescale 1ns/1ns
// Notes on behaviour
// - Low three scan bits pick highest digit
// - Refresh equals ten oscillator cycles over N+2
// - Upper five scan-limit bits are ignored
// - Feature register clears to zero at power-up
// - Bit 0 picks internal or pin clock
// - Soft-reset bit holds control registers other than the feature register at default
// - Digit data survives the soft reset
// - Bit 2 picks BCD or hex font
// - Blink only while enable bit set
// - Period bit picks one or two second blink
// - Sync bit clears timing on select rise
// - Start bit picks first blink phase
// - Lamp test lights all eight digits
module lsb_scan_blink import lsb_pkg::*; #(
  parameter int OSC_HZ = 700
) (
  input wire logic clk, // Core clock, 10 MHz
  input wire logic reset_n, // Asynchronous reset
  input wire logic reg_wr_en, // Register write strobe
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data, held
  input wire logic ext_clk_pin, // Serial interface clock pin
  input wire logic load_chip_select_pin, // Load/chip-select pin
  input wire logic visual_lamp_test, // Lamp test request
  input wire logic display_on, // Low while shut down
  output logic [LSB_DIGITS-1:0] digit_en, // One-hot digit drive
  output logic [LSB_LIMIT_W-1:0] digit_idx, // Active digit index
  output logic display_lit, // Blink lit phase
  output logic decode_hex, // Font select
  output logic ctrl_soft_reset // Soft reset to other control regs
);

  // ****************************************
  // Timing constants
  // ****************************************
  localparam int STEP_HZ = OSC_HZ * LSB_STEPS_PER_OSC;
  localparam int STEP_DIV = (LSB_CLK_HZ / STEP_HZ) < 1 ? 1 : LSB_CLK_HZ / STEP_HZ;
  localparam int FAST_STEPS = STEP_HZ * LSB_BLINK_FAST_HALF_MS / 1000;
  localparam int SLOW_STEPS = STEP_HZ * LSB_BLINK_SLOW_HALF_MS / 1000;
  localparam int DIV_W = $clog2(STEP_DIV + 1);
  localparam int BLK_W = $clog2(SLOW_STEPS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);
  localparam logic [BLK_W-1:0] FAST_LAST = BLK_W'(FAST_STEPS - 1);
  localparam logic [BLK_W-1:0] SLOW_LAST = BLK_W'(SLOW_STEPS - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] ck_sync_q, cs_sync_q;
  logic ck_prev_q, cs_prev_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ck_sync_q <= 2'h0;
      cs_sync_q <= 2'h0;
      ck_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else begin
      ck_sync_q <= {ck_sync_q[0], ext_clk_pin};
      cs_sync_q <= {cs_sync_q[0], load_chip_select_pin};
      ck_prev_q <= ck_sync_q[1];
      cs_prev_q <= cs_sync_q[1];
    end
  end

  logic ck_rise, cs_rise;
  assign ck_rise = ck_sync_q[1] & ~ck_prev_q;
  assign cs_rise = cs_sync_q[1] & ~cs_prev_q;

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] scan_q, scan_d, feat_q, feat_d, rdata_q, rdata_d;

  always_comb begin
    scan_d = scan_q;
    feat_d = feat_q;
    rdata_d = rdata_q;
    if (reg_wr_en && reg_addr == LSB_ADDR_SCAN) begin
      scan_d = reg_wdata;
    end
    if (reg_wr_en && reg_addr == LSB_ADDR_FEAT) begin
      feat_d = reg_wdata; // Bit 3 is stored but steers nothing
    end
    if (feat_d[LSB_F_SOFT_RST]) begin
      scan_d = LSB_SCAN_RST; // Feature register itself exempt
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        LSB_ADDR_SCAN: rdata_d = scan_q;
        LSB_ADDR_FEAT: rdata_d = feat_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_q <= LSB_SCAN_RST;
      feat_q <= LSB_FEAT_RST;
      rdata_q <= 8'h00;
    end else begin
      scan_q <= scan_d;
      feat_q <= feat_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Step divider
  // ****************************************
  // Parked while the pin clock is selected, so a switch back starts a whole step
  logic [DIV_W-1:0] div_q, div_d;
  logic step;

  always_comb begin
    div_d = div_q;
    step = 1'b0;
    if (feat_q[LSB_F_EXT_CLK]) begin
      step = ck_rise; // Pin clock drives the step directly
      div_d = '0;
    end else if (div_q == DIV_LAST) begin
      step = 1'b1; // Internal oscillator stand
      div_d = '0;
    end else begin
      div_d = div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ****************************************
  // Scan and blink timing
  // ****************************************
  logic [3:0] slot_q, slot_d;
  logic [BLK_W-1:0] blk_q, blk_d;
  logic phase_q, phase_d, blink_was_q, blink_was_d;
  logic [LSB_DIGITS-1:0] den_q, den_d;
  logic [LSB_LIMIT_W-1:0] idx_q, idx_d;
  logic lit_q, lit_d;
  logic [3:0] n_digits, slot_last;
  logic [BLK_W-1:0] half_last;

  always_comb begin
    // Lamp test scans all eight digits else low three bits only
    n_digits = visual_lamp_test ? 4'(LSB_DIGITS) : 4'({1'b0, scan_q[LSB_LIMIT_W-1:0]}) + 4'h1;
    slot_last = n_digits + 4'(LSB_IDLE_STEPS) - 4'h1; // N+2 steps per refresh
    half_last = feat_q[LSB_F_BLINK_SLOW] ? SLOW_LAST : FAST_LAST;
    slot_d = slot_q;
    blk_d = blk_q;
    phase_d = phase_q;
    blink_was_d = feat_q[LSB_F_BLINK_EN];
    if (feat_q[LSB_F_SYNC] && cs_rise) begin
      slot_d = 4'h0; // Multiplex and blink counters restart
      blk_d = '0;
      phase_d = feat_q[LSB_F_BLINK_START];
    end else if (step) begin
      slot_d = (slot_q >= slot_last) ? 4'h0 : slot_q + 4'h1;
      if (blk_q >= half_last) begin
        blk_d = '0;
        phase_d = ~phase_q;
      end else begin
        blk_d = blk_q + BLK_W'(1);
      end
    end
    if (feat_q[LSB_F_BLINK_EN] && !blink_was_q) begin
      blk_d = '0;
      phase_d = feat_q[LSB_F_BLINK_START]; // First phase dark or lit
    end
    // Lamp test overrides blink and shutdown
    lit_d = visual_lamp_test | ~feat_q[LSB_F_BLINK_EN] | phase_q;
    den_d = '0;
    idx_d = slot_q[LSB_LIMIT_W-1:0];
    if (slot_q < n_digits && lit_q && (display_on || visual_lamp_test)) begin
      den_d[slot_q[LSB_LIMIT_W-1:0]] = 1'b1; // One digit line at a time
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_q <= 4'h0;
      blk_q <= '0;
      phase_q <= 1'b0;
      blink_was_q <= 1'b0;
      den_q <= '0;
      idx_q <= '0;
      lit_q <= 1'b1;
    end else begin
      slot_q <= slot_d;
      blk_q <= blk_d;
      phase_q <= phase_d;
      blink_was_q <= blink_was_d;
      den_q <= den_d;
      idx_q <= idx_d;
      lit_q <= lit_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_q;
  assign digit_en = den_q;
  assign digit_idx = idx_q;
  assign display_lit = lit_q;
  assign decode_hex = feat_q[LSB_F_HEX];
  // Digit data lives elsewhere and must not clear on this
  assign ctrl_soft_reset = feat_q[LSB_F_SOFT_RST];

endmodule : lsb_scan_blink

/* File: tb/lsb_scan_blink_asserts.sv */
// Port checker for the LED scan and blink control
`timescale 1ns/1ns
module lsb_scan_blink_asserts (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic reg_wr_en, // Write
  input wire logic reg_rd_en, // Read
  input wire logic [7:0] reg_addr, // Offset
  input wire logic [7:0] reg_wdata, // Wdata
  input wire logic [7:0] reg_rdata, // Rdata
  input wire logic visual_lamp_test, // Lamp
  input wire logic display_on, // On
  input wire logic [7:0] digit_en, // Digits
  input wire logic display_lit, // Lit
  input wire logic decode_hex, // Font
  input wire logic ctrl_soft_reset // Soft reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ***
  // Checks
  // ***
  one_digit_a: assert property ($onehot0(digit_en)) else $error("two digits");
  lamp_lit_a: assert property (visual_lamp_test[*4] |-> display_lit) else $error("lamp dark");
  shut_dark_a: assert property ((!display_on && !visual_lamp_test)[*3] |-> digit_en == 8'h00) else $error("shutdown");
  soft_rst_a: assert property (reg_wr_en && reg_addr == 8'h0e |=> ctrl_soft_reset == $past(reg_wdata[1]))
    else $error("soft reset");
  hex_sel_a: assert property (reg_wr_en && reg_addr == 8'h0e |=> decode_hex == $past(reg_wdata[2]))
    else $error("font");
  scan_held_a: assert property (ctrl_soft_reset && reg_rd_en && reg_addr == 8'h0b |=> reg_rdata == 8'h00)
    else $error("scan held");
  blink_off_a: assert property (reg_wr_en && reg_addr == 8'h0e && !reg_wdata[4]
    ##1 !reg_wr_en[*3] |-> display_lit) else $error("blink off");
  feat_rw_a: assert property (reg_wr_en && reg_addr == 8'h0e ##1 !reg_wr_en ##1 reg_rd_en && !reg_wr_en &&
    reg_addr == 8'h0e |=> reg_rdata == $past(reg_wdata, 3)) else $error("feature rw");
  cover property (digit_en == 8'h80);
  cover property ($fell(display_lit));
  cover property (ctrl_soft_reset && reg_rd_en);
endmodule : lsb_scan_blink_asserts
bind lsb_scan_blink lsb_scan_blink_asserts chk_u (.clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .visual_lamp_test(visual_lamp_test), .display_on(display_on), .digit_en(digit_en),
  .display_lit(display_lit), .decode_hex(decode_hex), .ctrl_soft_reset(ctrl_soft_reset));

/* File: tb/lsb_led_model.sv */
// Display model that records which digit cathodes were driven
`timescale 1ns/1ns
module lsb_led_model (
  input wire logic clk, // Clock
  input wire logic clr, // Clear record
  input wire logic [7:0] digit_en, // Digit drive
  output logic [7:0] seen // Digits lit since clear
);
  always @(posedge clk) seen <= clr ? 8'h00 : seen | digit_en;
endmodule : lsb_led_model

/* File: tb/lsb_scan_blink_tb.sv */
// Bench for the LED scan and blink control
`timescale 1ns/1ns
module lsb_scan_blink_tb;
  localparam int OSC = 100;
  logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, pin = 1'b0, cs = 1'b0;
  logic lamp = 1'b0, on = 1'b1, clr = 1'b0, lit, hex, srst;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, den, seen;
  logic [2:0] didx;
  int fails = 0, cmp_count = 0, cyc = 0, half;
  always #50 clk = ~clk;
  lsb_scan_blink #(.OSC_HZ(OSC)) dut_u (.clk(clk), .reset_n(reset_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .ext_clk_pin(pin), .load_chip_select_pin(cs),
    .visual_lamp_test(lamp), .display_on(on), .digit_en(den), .digit_idx(didx), .display_lit(lit),
    .decode_hex(hex), .ctrl_soft_reset(srst));
  lsb_led_model led_u (.clk(clk), .clr(clr), .digit_en(den), .seen(seen));
  task stop_test();
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {addr, wdata, wr_en} = {a, d, 1'b1};
    @(negedge clk) wr_en = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) {addr, rd_en} = {a, 1'b1};
    @(negedge clk) rd_en = 1'b0;
    chk(rdata, e);
  endtask : rd
  // Slow pin pulses so the two-stage sync never merges edges
  task step(input int n);
    repeat (n) begin
      @(negedge clk) pin = 1'b1;
      repeat (4) @(negedge clk);
      pin = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask : step
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    rd(8'h0e, 8'h00);
    rd(8'h0a, 8'h00);
    wr(8'h0e, 8'h01);
    wr(8'h0b, 8'hf2); // Limit 2 from the low three bits, so only digits 0 to 2 scan and the upper bits are ignored
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    for (int k = 0; k < 10; k++) begin
      chk(den, (k % 5 < 3) ? 8'h01 << (k % 5) : 8'h00);
      chk({5'h00, didx}, 8'(k % 5));
      step(1);
    end
    chk(seen, 8'h07);
    wr(8'h0e, 8'h41);
    step(2);
    @(negedge clk) cs = 1'b1;
    repeat (8) @(negedge clk);
    chk(den, 8'h01);
    cs = 1'b0;
    wr(8'h0e, 8'h40);
    step(3);
    chk(den, 8'h01);
    $display("scan test done");
    wr(8'h0e, 8'h03);
    chk({7'h00, srst}, 8'h01);
    rd(8'h0b, 8'h00);
    wr(8'h0b, 8'h07);
    rd(8'h0b, 8'h00);
    wr(8'h0e, 8'h0d);
    rd(8'h0e, 8'h0d);
    chk({7'h00, hex}, 8'h01);
    chk({7'h00, lit}, 8'h01);
    $display("register test done");
    for (int m = 0; m < 2; m++) begin
      half = OSC * 5 * (m + 1);
      wr(8'h0e, 8'h01);
      wr(8'h0e, (m == 1) ? 8'h31 : 8'h11);
      repeat (2) @(negedge clk);
      chk({7'h00, lit}, 8'h00);
      step(half - 5);
      chk({7'h00, lit}, 8'h00);
      step(10);
      chk({7'h00, lit}, 8'h01);
    end
    wr(8'h0e, 8'h01);
    wr(8'h0e, 8'h91);
    repeat (2) @(negedge clk);
    chk({7'h00, lit}, 8'h01);
    wr(8'h0e, 8'h01);
    wr(8'h0e, 8'h11);
    repeat (2) @(negedge clk);
    chk({7'h00, lit}, 8'h00);
    wr(8'h0e, 8'h01);
    repeat (4) @(negedge clk);
    chk({7'h00, lit}, 8'h01);
    $display("blink test done");
    on = 1'b0;
    repeat (4) @(negedge clk);
    chk(den, 8'h00);
    lamp = 1'b1;
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    step(10);
    chk(seen, 8'hff);
    $display("lamp test done");
    stop_test();
  end
endmodule : lsb_scan_blink_tb
